/* File: rtl/usb_in_ep_pkg.sv */
package usb_in_ep_pkg;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] FLAGS_OFS  = 8'h08;
  localparam logic [7:0] DATA_OFS   = 8'h0c;
  localparam logic [7:0] INT_OFS    = 8'h10;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTL_CLR   = 7;
  localparam int CTL_OWEN  = 6;
  localparam int CTL_STALL = 3;
  localparam int CTL_PKT   = 1;
  localparam int CTL_EN    = 0;
  localparam int ST_TOG    = 7;
  localparam int ST_STALL  = 3;
  localparam int ST_NACK   = 2;
  localparam int ST_ERR    = 1;
  localparam int ST_ACK    = 0;
  localparam int FL_EMPTY  = 3;
  localparam int FL_FULL   = 2;
  localparam int FL_FIFO_UNDERRUN_FLAG   = 1;
  localparam int FL_FIFO_OVERRUN_FLAG   = 0;
  localparam int INT_BIT   = 0;
  // ------------------------------------------------------------
  // Reset values and sizes
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST  = 8'h08;
  localparam int         FIFO_DEPTH = 8;
  // ------------------------------------------------------------
  // Transaction states and answer kinds
  // ------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_BUSY} txn_state_t;
  typedef enum logic [1:0] {ANS_NONE, ANS_DATA, ANS_NACK, ANS_STALL} ans_t;
endpackage

/* File: rtl/tx_fifo_if.sv */
`timescale 1ns/1ps
interface tx_fifo_if #(parameter int W = 8);
  logic         push;
  logic         pop;
  logic         flush;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic         empty;
  logic         full;
  modport ctrl (output push, pop, flush, wdata, input rdata, empty, full);
  modport store (input push, pop, flush, wdata, output rdata, empty, full);
endinterface

/* File: rtl/tx_fifo.sv */
`timescale 1ns/1ps
module tx_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  tx_fifo_if.store  port
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0]   CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } fifo_st_t;

  fifo_st_t s_r;
  fifo_st_t s_nxt;

  // Flags and head word
  assign port.empty = (s_r.cnt == '0);
  assign port.full  = (s_r.cnt == CNT_FULL);
  assign port.rdata = s_r.mem[s_r.rp];

  // Pointer update, flush has priority
  always_comb begin
    s_nxt = s_r;
    if (port.flush) begin
      s_nxt.wp  = '0;
      s_nxt.rp  = '0;
      s_nxt.cnt = '0;
    end else begin
      if (port.push && !port.full) begin
        s_nxt.mem[s_r.wp] = port.wdata;
        s_nxt.wp = (s_r.wp == PTR_LAST) ? '0 : s_r.wp + 1'b1;
      end
      if (port.pop && !port.empty) begin
        s_nxt.rp = (s_r.rp == PTR_LAST) ? '0 : s_r.rp + 1'b1;
      end
      s_nxt.cnt = s_r.cnt + (AW+1)'(port.push && !port.full) - (AW+1)'(port.pop && !port.empty);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end
endmodule // tx_fifo

/* File: rtl/usb_in_endpoint_tx_status.sv */
`timescale 1ns/1ps
module usb_in_endpoint_tx_status #(
  parameter int FIFO_DEPTH = usb_in_ep_pkg::FIFO_DEPTH
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        in_token_i,
  input  wire logic        rd_byte_i,
  input  wire logic        txn_done_i,
  input  wire logic        host_ack_i,
  input  wire logic        txn_error_i,
  output logic             send_data_o,
  output logic             data_pid_o,
  output logic             send_stall_o,
  output logic             send_nack_o,
  output logic      [7:0]  byte_o,
  output logic             byte_valid_o,
  output logic             ep_tx_int_o,
  output logic             fifo_empty_o,
  output logic             fifo_full_o
);
  // ------------------------------------------------------------
  // State record
  // ------------------------------------------------------------
  typedef struct packed {
    usb_in_ep_pkg::txn_state_t state;
    usb_in_ep_pkg::ans_t       ans;
    logic       clr;
    logic       owen;
    logic       stall_req;
    logic       pkt_rdy;
    logic       tx_en;
    logic       tog;
    logic       stall;
    logic       nack;
    logic       err;
    logic       ack;
    logic       under;
    logic       over;
    logic       intr;
    logic       empty;
    logic       full;
    logic       wb_ack;
    logic [7:0] wb_dat;
    logic       send_data;
    logic       pid;
    logic       send_stall;
    logic       send_nack;
    logic [7:0] byte_q;
    logic       byte_v;
  } ep_st_t;

  localparam ep_st_t RST_VAL = '{
    state:      usb_in_ep_pkg::ST_IDLE,
    ans:        usb_in_ep_pkg::ANS_NONE,
    clr:        usb_in_ep_pkg::CTRL_RST[usb_in_ep_pkg::CTL_CLR],
    owen:       usb_in_ep_pkg::CTRL_RST[usb_in_ep_pkg::CTL_OWEN],
    stall_req:  usb_in_ep_pkg::CTRL_RST[usb_in_ep_pkg::CTL_STALL],
    pkt_rdy:    usb_in_ep_pkg::CTRL_RST[usb_in_ep_pkg::CTL_PKT],
    tx_en:      usb_in_ep_pkg::CTRL_RST[usb_in_ep_pkg::CTL_EN],
    tog:        usb_in_ep_pkg::STATUS_RST[usb_in_ep_pkg::ST_TOG],
    stall:      usb_in_ep_pkg::STATUS_RST[usb_in_ep_pkg::ST_STALL],
    nack:       usb_in_ep_pkg::STATUS_RST[usb_in_ep_pkg::ST_NACK],
    err:        usb_in_ep_pkg::STATUS_RST[usb_in_ep_pkg::ST_ERR],
    ack:        usb_in_ep_pkg::STATUS_RST[usb_in_ep_pkg::ST_ACK],
    under:      usb_in_ep_pkg::FLAGS_RST[usb_in_ep_pkg::FL_FIFO_UNDERRUN_FLAG],
    over:       usb_in_ep_pkg::FLAGS_RST[usb_in_ep_pkg::FL_FIFO_OVERRUN_FLAG],
    intr:       1'b0,
    empty:      usb_in_ep_pkg::FLAGS_RST[usb_in_ep_pkg::FL_EMPTY],
    full:       usb_in_ep_pkg::FLAGS_RST[usb_in_ep_pkg::FL_FULL],
    wb_ack:     1'b0,
    wb_dat:     8'h00,
    send_data:  1'b0,
    pid:        1'b0,
    send_stall: 1'b0,
    send_nack:  1'b0,
    byte_q:     8'h00,
    byte_v:     1'b0
  };

  ep_st_t     s_r;
  ep_st_t     s_nxt;
  logic       req;
  logic       wr;
  logic       done;
  logic [7:0] rd_mux;
  logic [7:0] wd;

  tx_fifo_if #(.W(8)) fif ();

  tx_fifo #(
    .W     (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .port      (fif.store)
  );

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // One-cycle answer to every access, writes need lane 0
  assign req  = wb_cyc_i & wb_stb_i & ~s_r.wb_ack;
  assign wr   = req & wb_we_i & wb_sel_i[0];
  assign wd   = wb_dat_i[7:0];
  assign done = (s_r.state == usb_in_ep_pkg::ST_BUSY) & txn_done_i;

  // Read view, reserved bits read zero
  always_comb begin
    unique case (wb_adr_i)
      usb_in_ep_pkg::CTRL_OFS:   rd_mux = {s_r.clr, s_r.owen, 2'b00, s_r.stall_req, 1'b0, s_r.pkt_rdy, s_r.tx_en};
      usb_in_ep_pkg::STATUS_OFS: rd_mux = {s_r.tog, 3'b000, s_r.stall, s_r.nack, s_r.err, s_r.ack};
      usb_in_ep_pkg::FLAGS_OFS:  rd_mux = {4'h0, s_r.empty, s_r.full, s_r.under, s_r.over};
      usb_in_ep_pkg::INT_OFS:    rd_mux = {7'h00, s_r.intr};
      default:                   rd_mux = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt            = s_r;
    s_nxt.wb_ack     = 1'b0;
    s_nxt.send_data  = 1'b0;
    s_nxt.send_stall = 1'b0;
    s_nxt.send_nack  = 1'b0;
    s_nxt.byte_v     = 1'b0;
    fif.push         = 1'b0;
    fif.pop          = 1'b0;
    fif.flush        = 1'b0;
    fif.wdata        = wd;
    // Flags mirror the FIFO one cycle late
    s_nxt.empty      = fif.empty;
    s_nxt.full       = fif.full;
    // FIFO clear runs one cycle after it is requested
    if (s_r.clr) begin
      fif.flush     = 1'b1;
      s_nxt.under   = 1'b0;
      s_nxt.over    = 1'b0;
      s_nxt.intr    = 1'b0;
      s_nxt.pkt_rdy = 1'b0;
      s_nxt.clr     = 1'b0;
    end
    if (req) begin
      s_nxt.wb_ack = 1'b1;
      s_nxt.wb_dat = rd_mux;
    end
    // Register writes
    if (wr) begin
      unique case (wb_adr_i)
        usb_in_ep_pkg::CTRL_OFS: begin
          s_nxt.clr       = wd[usb_in_ep_pkg::CTL_CLR];
          s_nxt.owen      = wd[usb_in_ep_pkg::CTL_OWEN];
          s_nxt.stall_req = wd[usb_in_ep_pkg::CTL_STALL];
          s_nxt.pkt_rdy   = wd[usb_in_ep_pkg::CTL_PKT];
          s_nxt.tx_en     = wd[usb_in_ep_pkg::CTL_EN];
        end
        usb_in_ep_pkg::STATUS_OFS: begin
          if (s_r.owen) begin
            s_nxt.tog = wd[usb_in_ep_pkg::ST_TOG];
          end
          if (!wd[usb_in_ep_pkg::ST_ACK] && s_r.ack) begin
            s_nxt.ack  = 1'b0;
            s_nxt.intr = 1'b0;
          end
        end
        usb_in_ep_pkg::DATA_OFS: begin
          if (fif.full) begin
            s_nxt.over = 1'b1;
            s_nxt.intr = 1'b1;
          end else begin
            fif.push = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // USB side pulls bytes of the packet
    if (rd_byte_i) begin
      if (fif.empty) begin
        s_nxt.under = 1'b1;
        s_nxt.intr  = 1'b1;
      end else begin
        fif.pop      = 1'b1;
        s_nxt.byte_q = fif.rdata;
        s_nxt.byte_v = 1'b1;
      end
    end
    // Transaction answer and outcome
    unique case (s_r.state)
      usb_in_ep_pkg::ST_IDLE: begin
        if (in_token_i) begin
          s_nxt.state = usb_in_ep_pkg::ST_BUSY;
          if (s_r.stall_req) begin
            s_nxt.ans        = usb_in_ep_pkg::ANS_STALL;
            s_nxt.send_stall = 1'b1;
          end else if (!s_r.tx_en || !s_r.pkt_rdy) begin
            s_nxt.ans       = usb_in_ep_pkg::ANS_NACK;
            s_nxt.send_nack = 1'b1;
          end else begin
            s_nxt.ans       = usb_in_ep_pkg::ANS_DATA;
            s_nxt.send_data = 1'b1;
            s_nxt.pid       = s_r.tog;
          end
        end
      end
      usb_in_ep_pkg::ST_BUSY: begin
        if (txn_done_i) begin
          s_nxt.state = usb_in_ep_pkg::ST_IDLE;
          s_nxt.stall = (s_r.ans == usb_in_ep_pkg::ANS_STALL);
          s_nxt.nack  = (s_r.ans == usb_in_ep_pkg::ANS_NACK);
          s_nxt.err   = txn_error_i;
          if (s_r.ans == usb_in_ep_pkg::ANS_DATA && host_ack_i && !txn_error_i) begin
            s_nxt.tog     = ~s_r.tog;
            s_nxt.ack     = 1'b1;
            s_nxt.intr    = 1'b1;
            s_nxt.pkt_rdy = 1'b0;
          end
        end
      end
    endcase
  end

  // State register, loaded with RST_VAL by power-on reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= RST_VAL;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign wb_dat_o     = {24'h000000, s_r.wb_dat};
  assign wb_ack_o     = s_r.wb_ack;
  assign send_data_o  = s_r.send_data;
  assign data_pid_o   = s_r.pid;
  assign send_stall_o = s_r.send_stall;
  assign send_nack_o  = s_r.send_nack;
  assign byte_o       = s_r.byte_q;
  assign byte_valid_o = s_r.byte_v;
  assign ep_tx_int_o  = s_r.intr;
  assign fifo_empty_o = s_r.empty;
  assign fifo_full_o  = s_r.full;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  pid_match_a: assert property (
    ce_i && s_r.state == usb_in_ep_pkg::ST_IDLE && in_token_i && !s_r.stall_req && s_r.tx_en && s_r.pkt_rdy
    |=> send_data_o && data_pid_o == $past(s_r.tog))
    else $error("Wrong data PID");

  toggle_flip_a: assert property (
    ce_i && done && s_r.ans == usb_in_ep_pkg::ANS_DATA && host_ack_i && !txn_error_i
    |=> s_r.tog != $past(s_r.tog))
    else $error("Toggle not inverted");

  toggle_lock_a: assert property (
    ce_i && wr && wb_adr_i == usb_in_ep_pkg::STATUS_OFS && !s_r.owen && !done
    |=> $stable(s_r.tog))
    else $error("Toggle written while locked");

  stall_stat_a: assert property (
    ce_i && done |=> s_r.stall == ($past(s_r.ans) == usb_in_ep_pkg::ANS_STALL))
    else $error("Stall status wrong");

  stall_ans_a: assert property (
    ce_i && !done && s_r.state == usb_in_ep_pkg::ST_IDLE && in_token_i && s_r.stall_req
    |=> send_stall_o && !send_data_o && !send_nack_o)
    else $error("STALL not answered");

  nack_stat_a: assert property (
    ce_i && done |=> s_r.nack == ($past(s_r.ans) == usb_in_ep_pkg::ANS_NACK))
    else $error("Nack status wrong");

  nack_ans_a: assert property (
    ce_i && s_r.state == usb_in_ep_pkg::ST_IDLE && in_token_i && !s_r.stall_req && !s_r.pkt_rdy
    |=> send_nack_o && !send_data_o)
    else $error("NACK not answered");

  err_stat_a: assert property (
    ce_i && done |=> s_r.err == $past(txn_error_i))
    else $error("Error status wrong");

  ack_set_a: assert property (
    ce_i && done && s_r.ans == usb_in_ep_pkg::ANS_DATA && host_ack_i && !txn_error_i
    |=> s_r.ack && ep_tx_int_o && !s_r.pkt_rdy)
    else $error("Ack or interrupt not set");

  ack_clear_a: assert property (
    ce_i && wr && wb_adr_i == usb_in_ep_pkg::STATUS_OFS && !wd[usb_in_ep_pkg::ST_ACK] && !done
    |=> !s_r.ack)
    else $error("Ack not cleared");

  flag_track_a: assert property (
    ce_i |=> fifo_empty_o == $past(fif.empty) && fifo_full_o == $past(fif.full))
    else $error("FIFO flags stale");

  under_set_a: assert property (
    ce_i && rd_byte_i && fif.empty |=> s_r.under && ep_tx_int_o && !byte_valid_o)
    else $error("Underrun not flagged");

  over_set_a: assert property (
    ce_i && wr && wb_adr_i == usb_in_ep_pkg::DATA_OFS && fif.full |=> s_r.over && ep_tx_int_o)
    else $error("Overrun not flagged");

  // Empty flag shows up one live cycle after the flush, so a frozen cycle is skipped
  clr_done_a: assert property (
    ce_i && s_r.clr && !wr && !rd_byte_i && !done
    |=> !s_r.clr && !s_r.under && !s_r.over && !ep_tx_int_o && !s_r.pkt_rdy
    ##1 (!$past(ce_i) || (fifo_empty_o && !fifo_full_o)))
    else $error("FIFO clear incomplete");
endmodule // usb_in_endpoint_tx_status

/* File: verification/usb_host_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host side: issues IN transactions and drains data bytes
// ------------------------------------------------------------
module usb_host_model (
  input  wire logic           clk_sys_i,
  input  wire logic           rst_n_i,
  input  wire logic           start_i,
  input  wire logic           ack_mode_i,
  input  wire logic           err_mode_i,
  input  wire logic [3:0]     nbytes_i,
  input  wire logic           send_data_i,
  input  wire logic           send_stall_i,
  input  wire logic           send_nack_i,
  output logic                in_token_o,
  output logic                rd_byte_o,
  output logic                txn_done_o,
  output logic                host_ack_o,
  output logic                txn_error_o,
  output logic                busy_o,
  output usb_in_ep_pkg::ans_t answer_o
);
  logic [2:0] phase_r;
  logic [3:0] cnt_r;

  // Sequencer: token, answer, byte reads, done; ack and error lines carry junk outside done
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_r     <= 3'h0;
      cnt_r       <= 4'h0;
      in_token_o  <= 1'b0;
      rd_byte_o   <= 1'b0;
      txn_done_o  <= 1'b0;
      host_ack_o  <= 1'b0;
      txn_error_o <= 1'b0;
      busy_o      <= 1'b0;
      answer_o    <= usb_in_ep_pkg::ANS_NONE;
    end else begin
      in_token_o  <= 1'b0;
      rd_byte_o   <= 1'b0;
      txn_done_o  <= 1'b0;
      host_ack_o  <= ~host_ack_o;
      txn_error_o <= ~txn_error_o;
      case (phase_r)
        3'h0: if (start_i) begin
          in_token_o <= 1'b1;
          busy_o     <= 1'b1;
          cnt_r      <= nbytes_i;
          answer_o   <= usb_in_ep_pkg::ANS_NONE;
          phase_r    <= 3'h1;
        end
        3'h1: if (send_data_i) begin
          answer_o <= usb_in_ep_pkg::ANS_DATA;
          phase_r  <= 3'h2;
        end else if (send_stall_i || send_nack_i) begin
          answer_o <= send_stall_i ? usb_in_ep_pkg::ANS_STALL : usb_in_ep_pkg::ANS_NACK;
          phase_r  <= 3'h3;
        end
        3'h2: if (cnt_r != 4'h0) begin
          rd_byte_o <= 1'b1;
          cnt_r     <= cnt_r - 4'h1;
        end else begin
          phase_r <= 3'h3;
        end
        3'h3: begin
          txn_done_o  <= 1'b1;
          host_ack_o  <= ack_mode_i && (answer_o == usb_in_ep_pkg::ANS_DATA);
          txn_error_o <= err_mode_i;
          phase_r     <= 3'h4;
        end
        default: begin
          busy_o  <= 1'b0;
          phase_r <= 3'h0;
        end
      endcase
    end
  end
endmodule // usb_host_model

/* File: verification/tb_usb_in_endpoint_tx_status.sv */
`timescale 1ns/1ps
module tb_usb_in_endpoint_tx_status;
  localparam int DEPTH = 8;
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                ce = 1'b1;
  logic                cyc = 1'b0;
  logic                stb = 1'b0;
  logic                we = 1'b0;
  logic [7:0]          adr = 8'h00;
  logic [3:0]          sel = 4'h0;
  logic [31:0]         wdat = 32'h0;
  logic [31:0]         rdat;
  logic                ack;
  logic                start = 1'b0;
  logic                amode = 1'b0;
  logic                emode = 1'b0;
  logic [3:0]          nbytes = 4'h0;
  logic                tok, rdb, done, hack, herr, busy;
  logic                sdata, pid, sstall, snack, bval, irq, fe, ff;
  logic [7:0]          byte_v;
  logic [7:0]          q;
  logic                tog = 1'b0;
  usb_in_ep_pkg::ans_t ans;
  int                  failures = 0;
  int                  tests_run = 0;
  int                  seed = 32'h7b652f9f;
  logic [7:0]          exp_q[$];
  logic [7:0]          got_q[$];

  // ------------------------------------------------------------
  // Clock, design, host model
  // ------------------------------------------------------------
  always #2.5 clk = ~clk;

  usb_in_endpoint_tx_status #(.FIFO_DEPTH(DEPTH)) u_usb_in_endpoint_tx_status (
    .clk_sys_i(clk), .rst_n_i(rst_n), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .in_token_i(tok), .rd_byte_i(rdb), .txn_done_i(done), .host_ack_i(hack), .txn_error_i(herr),
    .send_data_o(sdata), .data_pid_o(pid), .send_stall_o(sstall), .send_nack_o(snack),
    .byte_o(byte_v), .byte_valid_o(bval), .ep_tx_int_o(irq), .fifo_empty_o(fe), .fifo_full_o(ff));

  usb_host_model u_usb_host_model (
    .clk_sys_i(clk), .rst_n_i(rst_n), .start_i(start), .ack_mode_i(amode), .err_mode_i(emode),
    .nbytes_i(nbytes), .send_data_i(sdata), .send_stall_i(sstall), .send_nack_i(snack),
    .in_token_o(tok), .rd_byte_o(rdb), .txn_done_o(done), .host_ack_o(hack), .txn_error_o(herr),
    .busy_o(busy), .answer_o(ans));

  // Collects every byte handed to the host
  always @(posedge clk) if (bval === 1'b1) got_q.push_back(byte_v);

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    int n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= {24'h0, d};
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 64);
    if (n >= 64) chk(8'h00, 8'h01);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00, 4'hf);
    chk(q, exp);
  endtask

  // One IN transaction through the host model, answer compared
  task automatic host_txn(input logic [3:0] nb, input logic am, input logic em, input usb_in_ep_pkg::ans_t ea);
    int n = 0;
    @(posedge clk);
    start  <= 1'b1;
    nbytes <= nb;
    amode  <= am;
    emode  <= em;
    @(posedge clk);
    start <= 1'b0;
    do begin @(posedge clk); n++; end while (busy !== 1'b0 && n < 100);
    @(posedge clk);
    chk({6'h0, ans}, {6'h0, ea});
  endtask

  // Load n random bytes, send them, check toggle, status and ack clearing
  task automatic data_txn(input int n, input logic e);
    logic [7:0] b;
    exp_q.delete();
    got_q.delete();
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      exp_q.push_back(b);
      wr(usb_in_ep_pkg::DATA_OFS, b);
    end
    // Full flag trails the last push by one cycle
    if (n == DEPTH) begin
      @(posedge clk);
      chk({7'h0, ff}, 8'h01);
    end
    wr(usb_in_ep_pkg::CTRL_OFS, 8'h03);
    host_txn(4'(n), ~e, e, usb_in_ep_pkg::ANS_DATA);
    chk({7'h0, pid}, {7'h0, tog});
    chk(8'(got_q.size()), 8'(n));
    foreach (exp_q[i]) chk(got_q[i], exp_q[i]);
    if (!e) tog = ~tog;
    rdc(usb_in_ep_pkg::STATUS_OFS, e ? {tog, 7'h02} : {tog, 7'h01});
    rdc(usb_in_ep_pkg::INT_OFS, e ? 8'h00 : 8'h01);
    rdc(usb_in_ep_pkg::CTRL_OFS, e ? 8'h03 : 8'h01);
    wr(usb_in_ep_pkg::STATUS_OFS, 8'h00);
    rdc(usb_in_ep_pkg::INT_OFS, 8'h00);
    rdc(usb_in_ep_pkg::STATUS_OFS, e ? {tog, 7'h02} : {tog, 7'h00});
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk({7'h0, fe}, 8'h01);
    rdc(usb_in_ep_pkg::CTRL_OFS, 8'h00);
    rdc(usb_in_ep_pkg::STATUS_OFS, 8'h00);
    rdc(usb_in_ep_pkg::FLAGS_OFS, 8'h08);
    rdc(usb_in_ep_pkg::INT_OFS, 8'h00);
    rdc(8'h14, 8'h00);
    wb(1'b1, usb_in_ep_pkg::CTRL_OFS, 8'h08, 4'h0);
    rdc(usb_in_ep_pkg::CTRL_OFS, 8'h00);
    wr(usb_in_ep_pkg::CTRL_OFS, 8'h09);
    host_txn(4'h0, 1'b1, 1'b0, usb_in_ep_pkg::ANS_STALL);
    rdc(usb_in_ep_pkg::STATUS_OFS, 8'h08);
    wr(usb_in_ep_pkg::CTRL_OFS, 8'h00);
    host_txn(4'h0, 1'b1, 1'b0, usb_in_ep_pkg::ANS_NACK);
    rdc(usb_in_ep_pkg::STATUS_OFS, 8'h04);
    for (int k = 0; k < 5; k++) begin
      data_txn(k == 0 ? DEPTH : 1 + (($random(seed) & 32'h7fff) % DEPTH), k == 2);
    end
    wr(usb_in_ep_pkg::STATUS_OFS, {~tog, 7'h70});
    rdc(usb_in_ep_pkg::STATUS_OFS, {tog, 7'h00});
    wr(usb_in_ep_pkg::CTRL_OFS, 8'h40);
    wr(usb_in_ep_pkg::STATUS_OFS, {~tog, 7'h70});
    tog = ~tog;
    rdc(usb_in_ep_pkg::STATUS_OFS, {tog, 7'h00});
    wr(usb_in_ep_pkg::CTRL_OFS, 8'h00);
    data_txn(2, 1'b0);
    for (int i = 0; i <= DEPTH; i++) wr(usb_in_ep_pkg::DATA_OFS, 8'(i));
    rdc(usb_in_ep_pkg::FLAGS_OFS, 8'h05);
    chk({7'h0, irq}, 8'h01);
    wr(usb_in_ep_pkg::CTRL_OFS, 8'h80);
    // Freeze right after the flush: flags must not move until the enable returns
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    chk({6'h0, fe, ff}, 8'h01);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    chk({6'h0, fe, ff}, 8'h02);
    rdc(usb_in_ep_pkg::FLAGS_OFS, 8'h08);
    rdc(usb_in_ep_pkg::CTRL_OFS, 8'h00);
    rdc(usb_in_ep_pkg::INT_OFS, 8'h00);
    got_q.delete();
    wr(usb_in_ep_pkg::DATA_OFS, 8'h5a);
    wr(usb_in_ep_pkg::CTRL_OFS, 8'h03);
    host_txn(4'h3, 1'b0, 1'b0, usb_in_ep_pkg::ANS_DATA);
    rdc(usb_in_ep_pkg::FLAGS_OFS, 8'h0a);
    rdc(usb_in_ep_pkg::INT_OFS, 8'h01);
    chk(8'(got_q.size()), 8'h01);
    wr(usb_in_ep_pkg::CTRL_OFS, 8'h80);
    rdc(usb_in_ep_pkg::FLAGS_OFS, 8'h08);
    rdc(usb_in_ep_pkg::INT_OFS, 8'h00);
    complete_run();
  end

  // Watchdog far beyond the expected run length
  initial begin
    #200000;
    chk(8'h00, 8'h01);
    complete_run();
  end
endmodule // tb_usb_in_endpoint_tx_status
